/* File: hdl/mfd_decoder.sv */
// multi-function contact input decoder with AHB-Lite registers
// assumes contacts are asynchronous pins; drive status inputs share hclk
// Function
// R1: both speed-search codes assigned raises the setting error
// R2: only one of UP and DOWN assigned raises the setting error
// R3: UP, DOWN and ramp hold all assigned raises the setting error
// R4: code 00 on terminal 5 selects three-wire run mode
// R5: local/keypad source switch latched only while stopped
// R6: option card source switch latched only while stopped
// R7: jog select wins, else step inputs pick master, aux or stored references
// R8: code 07 closed selects second accel/decel pair, even mid-ramp
// R9: baseblock shuts output and indicates; release restarts at present reference
// R10: baseblock during stop deceleration also forces output frequency to zero
// R11: code 09 is baseblock on open contact
// R12: ramp hold freezes frequency; stop cancels; held value kept until release
// R13: overheat input blinks alarm, operation continues
// R14: only UP accelerates, only DOWN decelerates, else hold
// R15: UP/DOWN lower limit is the largest of three; held value retained
// R16: UP/DOWN ignored when reference source is keypad
// R17: forward and reverse jog run at jog reference with priority
// R18: both jogs closed 500 ms stops the drive
// R19: fault digit bit0 selects NC contact, bit1 running-only detection
// R20: fault digit bits 3:2 select ramp, coast, alternate ramp or minor
// R21: major fault shows terminal, stops, sets fault relay at once
// R22: minor fault alarm shows while active and at least 0.5 s
// R23: coast beats alternate ramp beats ordinary ramp among faults
// R24: code FF and reserved codes produce no command
//
// Design decisions made here: the AHB-Lite register port and the placing of the registers.
module mfd_decoder
  import mfd_pkg::*;
#(
  parameter int FREQ_W = 16,
  parameter int JOG_CYC = JOG_BOTH_CYC,
  parameter int MINOR_CYC = MINOR_SHOW_CYC
)(
  input wire logic hclk, // bus clock
  input wire logic hresetn, // async reset
  input wire logic hsel, // slave select
  input wire logic [7:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write
  input wire logic [2:0] hsize, // word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // always ready
  output logic [31:0] hrdata, // read data
  output logic hresp, // always okay
  input wire logic [3:0] contact_in, // terminals 5..8, high closed
  input wire logic run_cmd, // run command present
  input wire logic stop_cmd, // stop command present
  input wire logic drive_running, // output active
  input wire logic decel_stop, // decelerating after stop
  input wire logic [FREQ_W-1:0] out_freq, // present output frequency
  input wire logic [FREQ_W-1:0] min_output_frequency, // minimum output
  input wire logic [FREQ_W-1:0] reference_lower_limit, // lower limit
  input wire logic [FREQ_W-1:0] main_ref, // terminal reference
  output logic three_wire_q, // three-wire mode
  output logic keypad_src_q, // keypad source
  output logic option_src_q, // option card source
  output logic [3:0] ref_select_q, // 0 master 1 aux 2..7 stored 8 jog
  output logic accel_set2_q, // second ramp pair
  output logic baseblock_q, // output shut off
  output logic force_zero_q, // frequency to zero
  output logic restart_q, // restart pulse
  output logic ramp_hold_q, // freeze frequency
  output logic [FREQ_W-1:0] held_freq_q, // held frequency
  output logic overheat_q, // overheat indication
  output logic up_q, // accelerate
  output logic down_q, // decelerate
  output logic [FREQ_W-1:0] lower_limit_q, // updown lower limit
  output logic jog_fwd_q, // forward jog
  output logic jog_rev_q, // reverse jog
  output logic jog_stop_q, // both jogs stop
  output logic fault_relay_q, // major fault relay
  output logic [1:0] stop_mode_q, // fault stop response
  output logic [3:0] fault_term_q, // fault terminal number
  output logic [3:0] minor_alarm_q, // per terminal alarm
  output logic setting_error_q // code conflict
);
  // ==========================================
  // contact synchroniser
  logic [3:0] cmeta_q, csync_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cmeta_q <= 4'h0;
      csync_q <= 4'h0;
    end
    else
    begin
      cmeta_q <= contact_in;
      csync_q <= cmeta_q;
    end
  end
  // ==========================================
  // bus registers
  logic [31:0] func_q;
  logic ref_keypad_q;
  logic [3:0] fault_q;
  logic hold_valid_q;
  logic wr_q;
  logic [7:0] wa_q;
  logic addr_ph;
  logic [31:0] rd_d;
  assign addr_ph = hsel & htrans[1] & hready;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      wr_q <= addr_ph & hwrite;
      wa_q <= haddr;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      func_q <= FUNC_RST;
      ref_keypad_q <= CTRL_RST;
    end
    else if (wr_q)
    begin
      if (wa_q == ADDR_FUNC)
        func_q <= hwdata;
      if (wa_q == ADDR_CTRL)
        ref_keypad_q <= hwdata[0];
    end
  end
  always_comb
  begin
    rd_d = 32'h00000000;
    unique case (haddr)
      ADDR_FUNC: rd_d = func_q;
      ADDR_CTRL: rd_d = {31'h0, ref_keypad_q};
      ADDR_STATUS: rd_d = {20'h0, csync_q, jog_stop_q, overheat_q, ramp_hold_q, baseblock_q,
                           minor_alarm_q[3:1] != 3'h0 || minor_alarm_q[0], option_src_q, keypad_src_q,
                           setting_error_q};
      ADDR_FAULT: rd_d = {28'h0, fault_q};
      ADDR_HOLD: rd_d = {15'h0, hold_valid_q, 16'(held_freq_q)};
      default: rd_d = 32'h00000000;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (addr_ph & ~hwrite)
      hrdata <= rd_d;
  end
  // ==========================================
  // per-terminal decode
  logic [3:0] a_local, a_opt, a_s1, a_s2, a_s3, a_jog, a_acc, a_bbno, a_bbnc;
  logic [3:0] a_hold, a_oh, a_up, a_dn, a_fj, a_rj, a_m61, a_m62;
  logic [3:0] ef_det, ef_major, ef_coast, ef_alt, ef_minor;
  for (genvar t = 0; t < 4; t++)
  begin : g_term
    logic [7:0] fc;
    logic is_ef;
    assign fc = func_q[8*t +: 8];
    assign a_local[t] = fc == FC_LOCAL;
    assign a_opt[t] = fc == FC_OPTION;
    assign a_s1[t] = fc == FC_STEP1;
    assign a_s2[t] = fc == FC_STEP2;
    assign a_s3[t] = fc == FC_STEP3;
    assign a_jog[t] = fc == FC_JOGSEL;
    assign a_acc[t] = fc == FC_ACC2;
    assign a_bbno[t] = fc == FC_BB_NO;
    assign a_bbnc[t] = fc == FC_BB_NC;
    assign a_hold[t] = fc == FC_HOLD;
    assign a_oh[t] = fc == FC_OH;
    assign a_up[t] = fc == FC_UP;
    assign a_dn[t] = fc == FC_DOWN;
    assign a_fj[t] = fc == FC_FORWARD_JOG_INPUT;
    assign a_rj[t] = fc == FC_REVERSE_JOG_INPUT;
    assign a_m61[t] = fc == FC_SRCH_MAX;
    assign a_m62[t] = fc == FC_SRCH_SET;
    assign is_ef = fc[7:4] >= FC_EF_FIRST && fc[7:4] <= FC_EF_LAST; // R24
    assign ef_det[t] = is_ef && (csync_q[t] ^ fc[EF_NC_BIT]) && (!fc[EF_RUN_BIT] || drive_running); // R19
    assign ef_major[t] = ef_det[t] && fc[EF_RESP_LSB +: 2] != RESP_MINOR; // R20
    assign ef_coast[t] = is_ef && fc[EF_RESP_LSB +: 2] == RESP_COAST;
    assign ef_alt[t] = is_ef && fc[EF_RESP_LSB +: 2] == RESP_ALT;
    assign ef_minor[t] = ef_det[t] && fc[EF_RESP_LSB +: 2] == RESP_MINOR;
    logic [CNT_W-1:0] show_q;
    logic alarm_q;
    assign minor_alarm_q[t] = alarm_q;
    // minor alarm stretched to the minimum display time
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        show_q <= '0;
        alarm_q <= 1'b0;
      end
      else
      begin
        if (ef_minor[t])
          show_q <= CNT_W'(MINOR_CYC - 1); // R22
        else if (show_q != '0)
          show_q <= show_q - 1'b1;
        alarm_q <= ef_minor[t] || show_q != '0; // R22
      end
    end
  end
  logic [3:0] cl;
  assign cl = csync_q;
  // ==========================================
  // setting check and sources
  logic err_d, have_ud;
  assign have_ud = |a_up && |a_dn;
  assign err_d = (|a_m61 && |a_m62) // R1
               || (|a_up != |a_dn) // R2
               || (have_ud && |a_hold); // R3
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      setting_error_q <= 1'b0;
      three_wire_q <= 1'b0;
      keypad_src_q <= 1'b0;
      option_src_q <= 1'b0;
    end
    else
    begin
      setting_error_q <= err_d;
      three_wire_q <= func_q[7:0] == FC_3WIRE; // R4
      if (!drive_running)
      begin
        keypad_src_q <= |(a_local & cl); // R5
        option_src_q <= |a_opt && !(|(a_opt & cl)); // R6
      end
    end
  end
  // ==========================================
  // reference, ramp and baseblock
  logic bb_on, bb_prev_q;
  assign bb_on = |(a_bbno & cl) || |(a_bbnc & ~cl); // R11
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ref_select_q <= 4'h0;
      accel_set2_q <= 1'b0;
      overheat_q <= 1'b0;
    end
    else
    begin
      if (|(a_jog & cl))
        ref_select_q <= REF_JOG; // R7
      else
        ref_select_q <= {1'b0, |(a_s3 & cl), |(a_s2 & cl), |(a_s1 & cl)}; // R7
      accel_set2_q <= |(a_acc & cl); // R8
      overheat_q <= |(a_oh & cl); // R13
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      baseblock_q <= 1'b0;
      force_zero_q <= 1'b0;
      restart_q <= 1'b0;
      bb_prev_q <= 1'b0;
    end
    else
    begin
      bb_prev_q <= bb_on;
      baseblock_q <= bb_on; // R9
      if (bb_on && decel_stop)
        force_zero_q <= 1'b1; // R10
      else if (!bb_on)
        force_zero_q <= 1'b0;
      restart_q <= bb_prev_q && !bb_on && run_cmd && !stop_cmd; // R9
    end
  end
  // ==========================================
  // ramp hold and held frequency
  logic hold_on;
  assign hold_on = |(a_hold & cl);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ramp_hold_q <= 1'b0;
      hold_valid_q <= 1'b0;
      held_freq_q <= '0;
    end
    else
    begin
      ramp_hold_q <= hold_on && run_cmd && !stop_cmd; // R12
      if (!hold_on && !up_q && !down_q && !(have_ud && run_cmd))
        hold_valid_q <= 1'b0; // R12
      else if (hold_on && !hold_valid_q && run_cmd)
      begin
        hold_valid_q <= 1'b1; // R12
        held_freq_q <= out_freq;
      end
      else if (have_ud && run_cmd && !up_q && !down_q)
      begin
        hold_valid_q <= 1'b1; // R15
        held_freq_q <= out_freq;
      end
      else if (wr_q && wa_q == ADDR_HOLD)
      begin
        hold_valid_q <= hwdata[HOLD_VALID_BIT];
        held_freq_q <= FREQ_W'(hwdata[15:0]);
      end
    end
  end
  // ==========================================
  // up/down and jog
  logic fj_on, rj_on;
  logic [CNT_W-1:0] jog_cnt_q;
  logic [FREQ_W-1:0] lim_a;
  assign fj_on = |(a_fj & cl);
  assign rj_on = |(a_rj & cl);
  assign lim_a = min_output_frequency > reference_lower_limit ? min_output_frequency : reference_lower_limit;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      up_q <= 1'b0;
      down_q <= 1'b0;
      lower_limit_q <= '0;
    end
    else
    begin
      up_q <= have_ud && !ref_keypad_q && run_cmd && !fj_on && !rj_on && |(a_up & cl) && !(|(a_dn & cl)); // R14
      down_q <= have_ud && !ref_keypad_q && run_cmd && !fj_on && !rj_on && |(a_dn & cl) && !(|(a_up & cl)); // R16
      lower_limit_q <= lim_a > main_ref ? lim_a : main_ref; // R15
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      jog_cnt_q <= '0;
      jog_stop_q <= 1'b0;
      jog_fwd_q <= 1'b0;
      jog_rev_q <= 1'b0;
    end
    else
    begin
      if (!(fj_on && rj_on))
        jog_cnt_q <= '0;
      else if (jog_cnt_q != CNT_W'(JOG_CYC - 1))
        jog_cnt_q <= jog_cnt_q + 1'b1;
      jog_stop_q <= fj_on && rj_on && jog_cnt_q == CNT_W'(JOG_CYC - 1); // R18
      jog_fwd_q <= fj_on && !rj_on; // R17
      jog_rev_q <= rj_on && !fj_on; // R17
    end
  end
  // ==========================================
  // external fault latch and response
  logic [3:0] clr;
  assign clr = (wr_q && wa_q == ADDR_FAULT) ? hwdata[3:0] : 4'h0;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fault_q <= 4'h0;
      fault_relay_q <= 1'b0;
      stop_mode_q <= RESP_RAMP;
      fault_term_q <= 4'h0;
    end
    else
    begin
      fault_q <= (fault_q & ~clr) | ef_major;
      fault_relay_q <= |((fault_q & ~clr) | ef_major); // R21
      if (|((fault_q | ef_major) & ef_coast))
        stop_mode_q <= RESP_COAST; // R23
      else if (|((fault_q | ef_major) & ef_alt))
        stop_mode_q <= RESP_ALT; // R23
      else
        stop_mode_q <= RESP_RAMP;
      if (ef_major[0] || fault_q[0])
        fault_term_q <= 4'h5; // R21
      else if (ef_major[1] || fault_q[1])
        fault_term_q <= 4'h6;
      else if (ef_major[2] || fault_q[2])
        fault_term_q <= 4'h7;
      else if (ef_major[3] || fault_q[3])
        fault_term_q <= 4'h8;
      else
        fault_term_q <= 4'h0;
    end
  end
  // ==========================================
  // checks
  sequence jog_both_s;
    fj_on && rj_on && jog_cnt_q == CNT_W'(JOG_CYC - 1);
  endsequence
  chk_search_pair: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    (|a_m61 && |a_m62) |=> setting_error_q) else $error("search pair not flagged");
  chk_updown_single: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    (|a_up != |a_dn) |=> setting_error_q) else $error("single up/down not flagged");
  chk_source_latch: assert property (@(posedge hclk) disable iff (!hresetn) // R5
    drive_running |=> $stable(keypad_src_q) && $stable(option_src_q)) else $error("source changed running");
  chk_jog_select: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    |(a_jog & cl) |=> ref_select_q == REF_JOG) else $error("jog reference not selected");
  chk_bb_zero: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    bb_on && decel_stop |=> force_zero_q && baseblock_q) else $error("baseblock decel not zeroed");
  chk_jog_prio: assert property (@(posedge hclk) disable iff (!hresetn) // R17
    (fj_on || rj_on) |=> !up_q && !down_q) else $error("updown active during jog");
  chk_jog_stop: assert property (@(posedge hclk) disable iff (!hresetn) // R18
    jog_both_s |=> jog_stop_q) else $error("double jog not stopped");
  chk_fault_relay: assert property (@(posedge hclk) disable iff (!hresetn) // R21
    |ef_major |=> fault_relay_q ##1 (fault_relay_q || $past(clr) != 4'h0)) else $error("fault relay late");
  chk_minor_show: assert property (@(posedge hclk) disable iff (!hresetn) // R22
    ef_minor[0] ##1 !ef_minor[0] |-> minor_alarm_q[0] [*2]) else $error("minor alarm too short");
  chk_coast_first: assert property (@(posedge hclk) disable iff (!hresetn) // R23
    |(ef_major & ef_coast) |=> stop_mode_q == RESP_COAST) else $error("coast not preferred");
endmodule : mfd_decoder

/* File: hdl/mfd_pkg.sv */
// constants for the multi-function contact decoder
// assumes a 200 MHz hclk and word-only AHB-Lite access
package mfd_pkg;
  // ==========================================
  // function codes
  localparam logic [7:0] FC_3WIRE = 8'h00;
  localparam logic [7:0] FC_LOCAL = 8'h01;
  localparam logic [7:0] FC_OPTION = 8'h02;
  localparam logic [7:0] FC_STEP1 = 8'h03;
  localparam logic [7:0] FC_STEP2 = 8'h04;
  localparam logic [7:0] FC_STEP3 = 8'h05;
  localparam logic [7:0] FC_JOGSEL = 8'h06;
  localparam logic [7:0] FC_ACC2 = 8'h07;
  localparam logic [7:0] FC_BB_NO = 8'h08;
  localparam logic [7:0] FC_BB_NC = 8'h09;
  localparam logic [7:0] FC_HOLD = 8'h0A;
  localparam logic [7:0] FC_OH = 8'h0B;
  localparam logic [7:0] FC_UP = 8'h10;
  localparam logic [7:0] FC_DOWN = 8'h11;
  localparam logic [7:0] FC_FORWARD_JOG_INPUT = 8'h12;
  localparam logic [7:0] FC_REVERSE_JOG_INPUT = 8'h13;
  localparam logic [7:0] FC_SRCH_MAX = 8'h61;
  localparam logic [7:0] FC_SRCH_SET = 8'h62;
  localparam logic [3:0] FC_EF_FIRST = 4'h2;
  localparam logic [3:0] FC_EF_LAST = 4'h5;
  localparam int EF_NC_BIT = 0;
  localparam int EF_RUN_BIT = 1;
  localparam int EF_RESP_LSB = 2;
  localparam logic [1:0] RESP_RAMP = 2'h0;
  localparam logic [1:0] RESP_COAST = 2'h1;
  localparam logic [1:0] RESP_ALT = 2'h2;
  localparam logic [1:0] RESP_MINOR = 2'h3;
  localparam logic [3:0] REF_JOG = 4'h8;
  // ==========================================
  // register map
  localparam logic [7:0] ADDR_FUNC = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_FAULT = 8'h0C;
  localparam logic [7:0] ADDR_HOLD = 8'h10;
  localparam logic [31:0] FUNC_RST = 32'hFFFFFFFF;
  localparam logic CTRL_RST = 1'h0;
  localparam int HOLD_VALID_BIT = 16;
  // ==========================================
  // timing
  localparam int CLK_KHZ = 200000;
  localparam int JOG_BOTH_MS = 500;
  localparam int MINOR_SHOW_MS = 500;
  localparam int JOG_BOTH_CYC = CLK_KHZ * JOG_BOTH_MS;
  localparam int MINOR_SHOW_CYC = CLK_KHZ * MINOR_SHOW_MS;
  localparam int CNT_W = 27;
endpackage : mfd_pkg

/* File: dv/mfd_contacts.sv */
// model of the switch contacts wired to terminals 5..8
// assumes the bench asks for contact states; a contact moves just after hclk rises
module mfd_contacts
(
  input wire logic hclk, // sampling clock
  input wire logic [3:0] closed_req, // wanted states, high closed
  output logic [3:0] contact_in // pins to the decoder
);
  timeunit 1ns;
  timeprecision 100ps;
  // contacts are plain pins, no bounce modelled
  always @(posedge hclk) contact_in <= closed_req;
endmodule : mfd_contacts

/* File: dv/tb.sv */
// self-checking bench for the multi-function contact decoder
// assumes mfd_pkg, mfd_decoder and mfd_contacts are compiled first
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import mfd_pkg::*;
  // ==========================================
  // signals
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hreadyout, hresp;
  logic run_cmd, stop_cmd, drive_running, decel_stop;
  logic [7:0] haddr;
  logic [1:0] htrans, stop_mode_q;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  logic [3:0] closed, contact_in, ref_select_q, fault_term_q, minor_alarm_q;
  logic [15:0] out_freq, min_output_frequency, reference_lower_limit, main_ref, held_freq_q, lower_limit_q;
  logic three_wire_q, keypad_src_q, option_src_q, accel_set2_q, baseblock_q, force_zero_q, restart_q;
  logic ramp_hold_q, overheat_q, up_q, down_q, jog_fwd_q, jog_rev_q, jog_stop_q, fault_relay_q, setting_error_q;
  int n_mismatch = 0;
  int num_checks = 0;
  int n_restart = 0;
  int k;
  logic [31:0] se_f [5] = '{32'hFFFFFF10, 32'hFFFF1110, 32'hFF0A1110, 32'hFFFF6261, 32'hFFFFFF61};
  logic se_e [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  always #2.5 hclk = ~hclk;
  always @(posedge hclk) if (restart_q === 1'b1) n_restart <= n_restart + 1;
  mfd_contacts u_sw (.hclk, .closed_req(closed), .contact_in);
  mfd_decoder #(.JOG_CYC(20), .MINOR_CYC(10)) DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .contact_in, .run_cmd, .stop_cmd, .drive_running,
    .decel_stop, .out_freq, .min_output_frequency, .reference_lower_limit, .main_ref, .three_wire_q,
    .keypad_src_q, .option_src_q, .ref_select_q, .accel_set2_q, .baseblock_q, .force_zero_q, .restart_q,
    .ramp_hold_q, .held_freq_q, .overheat_q, .up_q, .down_q, .lower_limit_q, .jog_fwd_q, .jog_rev_q,
    .jog_stop_q, .fault_relay_q, .stop_mode_q, .fault_term_q, .minor_alarm_q, .setting_error_q);
  // ==========================================
  // tasks
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wait_rdy;
    int i;
    i = 0;
    do
    begin
      @(posedge hclk);
      i++;
    end
    while (hreadyout !== 1'b1 && i < 50);
    if (hreadyout !== 1'b1)
    begin
      n_mismatch++;
      summarize();
    end
  endtask : wait_rdy
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask : rdc
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] r;
    bus(1'b1, a, v, r);
    repeat (2) @(posedge hclk);
  endtask : wr
  // program codes, set contacts, let them pass the synchroniser
  task automatic cfg(input logic [31:0] f, input logic [3:0] c);
    wr(ADDR_FUNC, f);
    closed <= c;
    repeat (6) @(posedge hclk);
  endtask : cfg
  // ==========================================
  // sequence
  initial
  begin
    {hresetn, hsel, hwrite, run_cmd, stop_cmd, drive_running, decel_stop} = '0;
    {haddr, htrans, hsize, hwdata, closed} = '0;
    {out_freq, min_output_frequency, reference_lower_limit, main_ref} = '0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(ADDR_FUNC, FUNC_RST);
    chk({hresp, hreadyout}, 2'b01);
    rdc(8'h14, 32'h0);
    cfg(FUNC_RST, 4'hF);
    chk({three_wire_q, option_src_q, ref_select_q, accel_set2_q, baseblock_q, up_q, jog_fwd_q, fault_relay_q}, 0);
    for (k = 0; k < 5; k++)
    begin
      cfg(se_f[k], 4'h0);
      chk(setting_error_q, se_e[k]);
    end
    cfg(32'hFFFFFF00, 4'h0);
    chk(three_wire_q, 1'b1);
    cfg(32'hFFFF00FF, 4'h0);
    chk(three_wire_q, 1'b0);
    cfg(32'hFFFFFF01, 4'h1);
    chk(keypad_src_q, 1'b1);
    drive_running <= 1'b1;
    cfg(32'hFFFFFF01, 4'h0);
    chk(keypad_src_q, 1'b1);
    drive_running <= 1'b0;
    cfg(32'hFFFFFF01, 4'h0);
    chk(keypad_src_q, 1'b0);
    cfg(32'hFFFFFF02, 4'h0);
    chk(option_src_q, 1'b1);
    cfg(32'hFFFFFF02, 4'h1);
    chk(option_src_q, 1'b0);
    for (k = 0; k < 16; k++)
    begin
      cfg(32'h06050403, k[3:0]);
      chk(ref_select_q, k[3] ? 4'h8 : {1'b0, k[2:0]});
    end
    run_cmd <= 1'b1;
    drive_running <= 1'b1;
    cfg(32'h0B090807, 4'h4);
    chk({accel_set2_q, baseblock_q, overheat_q}, 3'b000);
    cfg(32'h0B090807, 4'hF);
    chk({accel_set2_q, baseblock_q, overheat_q}, 3'b111);
    k = n_restart;
    cfg(32'h0B090807, 4'h4);
    chk(n_restart - k, 1);
    cfg(32'h0B090807, 4'h0);
    chk(baseblock_q, 1'b1);
    rdc(ADDR_STATUS, 32'h00000010);
    run_cmd <= 1'b0;
    stop_cmd <= 1'b1;
    decel_stop <= 1'b1;
    cfg(32'h0B090807, 4'h6);
    chk({baseblock_q, force_zero_q}, 2'b11);
    {stop_cmd, decel_stop} <= 2'b00;
    run_cmd <= 1'b1;
    out_freq <= 16'h1234;
    cfg(32'hFFFFFF0A, 4'h1);
    out_freq <= 16'h2000;
    repeat (4) @(posedge hclk);
    chk({ramp_hold_q, held_freq_q}, 17'h11234);
    run_cmd <= 1'b0;
    stop_cmd <= 1'b1;
    repeat (4) @(posedge hclk);
    chk({ramp_hold_q, held_freq_q}, 17'h01234);
    rdc(ADDR_HOLD, 32'h00011234);
    stop_cmd <= 1'b0;
    run_cmd <= 1'b1;
    min_output_frequency <= 16'h0100;
    reference_lower_limit <= 16'h0300;
    main_ref <= 16'h0200;
    for (k = 0; k < 4; k++)
    begin
      cfg(32'hFFFF1110, k[3:0]);
      chk({up_q, down_q}, k == 1 ? 2'b10 : k == 2 ? 2'b01 : 2'b00);
    end
    chk(lower_limit_q, 16'h0300);
    wr(ADDR_CTRL, 32'h1);
    cfg(32'hFFFF1110, 4'h1);
    chk(up_q, 1'b0);
    wr(ADDR_CTRL, 32'h0);
    cfg(32'hFFFF1312, 4'h1);
    chk({jog_fwd_q, jog_rev_q}, 2'b10);
    cfg(32'hFFFF1312, 4'h2);
    chk({jog_fwd_q, jog_rev_q}, 2'b01);
    cfg(32'hFFFF1312, 4'h3);
    chk(jog_stop_q, 1'b0);
    repeat (25) @(posedge hclk);
    chk(jog_stop_q, 1'b1);
    {run_cmd, drive_running} <= 2'b00;
    cfg(32'hFFFFFF24, 4'h1);
    chk({fault_relay_q, stop_mode_q, fault_term_q}, 7'h55);
    rdc(ADDR_FAULT, 32'h00000001);
    cfg(32'hFFFFFF24, 4'h0);
    wr(ADDR_FAULT, 32'hF);
    chk(fault_relay_q, 1'b0);
    cfg(32'hFFFFFF25, 4'h0);
    chk(fault_relay_q, 1'b1);
    cfg(32'hFFFFFF25, 4'h1);
    wr(ADDR_FAULT, 32'hF);
    cfg(32'hFFFFFF26, 4'h1);
    chk(fault_relay_q, 1'b0);
    for (k = 0; k < 3; k++)
    begin
      cfg(32'hFFFFFF20 | (k << 2), 4'h1);
      chk({fault_relay_q, stop_mode_q}, {1'b1, k[1:0]});
      cfg(32'hFFFFFF20, 4'h0);
      wr(ADDR_FAULT, 32'hF);
    end
    cfg(32'hFFFF3428, 4'h3);
    chk(stop_mode_q, RESP_COAST);
    cfg(32'hFFFF3820, 4'h3);
    chk(stop_mode_q, RESP_ALT);
    cfg(32'hFFFF3820, 4'h0);
    wr(ADDR_FAULT, 32'hF);
    cfg(32'hFFFFFF2C, 4'h0);
    closed <= 4'h1;
    @(posedge hclk);
    closed <= 4'h0;
    repeat (8) @(posedge hclk);
    chk({minor_alarm_q, fault_relay_q}, 5'h02);
    repeat (20) @(posedge hclk);
    chk(minor_alarm_q, 4'h0);
    summarize();
  end
endmodule : tb
